// ==== common/cdiv_regs.svh ====
`ifndef CDIV_REGS_SVH
`define CDIV_REGS_SVH

`define CDIV_CH3_CNT1  9'h199
`define CDIV_CH3_PHASE 9'h19A
`define CDIV_CH3_CNT2  9'h19B
`define CDIV_CH3_START 9'h19C
`define CDIV_CH3_DUTY  9'h19D
`define CDIV_CH4_CNT1  9'h19E
`define CDIV_CH4_PHASE 9'h19F
`define CDIV_CH4_CNT2  9'h1A0
`define CDIV_CH4_START 9'h1A1
`define CDIV_CH4_DUTY  9'h1A2
`define CDIV_CTRL      9'h1A4
`define CDIV_STATUS    9'h1A5

`define CDIV_START1_BIT   0
`define CDIV_START2_BIT   1
`define CDIV_BYP1_BIT     4
`define CDIV_BYP2_BIT     5
`define CDIV_DUTY_OFF_BIT 0
`define CDIV_HOLD_BIT  0
`define CDIV_SRC_BIT   1

`define CDIV_REG_RESET 8'h00
`define CDIV_SYNC_STAGES 2

`endif

// ==== common/cdiv_pkg.sv ====
package cdiv_pkg;

    typedef struct packed {
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
        logic [3:0] coarse_phase_steps;
        logic       initial_level_high;
        logic       bypass;
        logic       dcc_en;
    } stage_cfg_type;

    typedef enum logic [2:0] {
        PH_HOLD,
        PH_DELAY,
        PH_HIGH,
        PH_FALL,
        PH_LOW
    } stage_phase_type;

    typedef struct packed {
        stage_phase_type ph;
        logic [5:0]      cnt;
        logic            in_prev;
        logic            out;
    } stage_state_type;

    typedef struct packed {
        logic [7:0] cnt1;
        logic [7:0] phase;
        logic [7:0] cnt2;
        logic [7:0] start;
        logic       dcc_off;
    } chan_regs_type;

    typedef struct packed {
        chan_regs_type ch3;
        chan_regs_type ch4;
        logic          hold;
        logic          src_pre;
        logic          wait_req;
        logic [31:0]   rdata;
        logic          ch3_clk;
        logic          ch4_clk;
    } top_state_type;

endpackage : cdiv_pkg

// ==== hdl/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
    parameter int W = 1
)
(
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level
);
    import cdiv_pkg::*;

    // First row is metastable; only the second row is read
    logic [1:0][W-1:0] s_q;
    logic [1:0][W-1:0] s_d;

    always_comb
    begin
        s_d    = s_q;
        s_d[0] = i_pin;
        s_d[1] = s_q[0];
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else if (i_ce)
            s_q <= s_d;
    end

    assign o_level = s_q[1];

endmodule : pin_sync
`default_nettype wire

// ==== hdl/div_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module div_stage
(
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_ce,
    input  wire logic                    i_in,
    input  wire logic                    i_run,
    input  wire cdiv_pkg::stage_cfg_type i_cfg,
    output logic                         o_out
);
    import cdiv_pkg::*;

    stage_state_type s_q;
    stage_state_type s_d;
    logic            rise;
    logic            fall;
    logic            odd_dcc;
    logic [5:0]      delay;
    logic [5:0]      high6;
    logic [5:0]      low6;

    assign rise    = i_in & ~s_q.in_prev;
    assign fall    = ~i_in & s_q.in_prev;
    assign high6   = {2'h0, i_cfg.high_cnt};
    assign low6    = {2'h0, i_cfg.low_cnt};
    // Odd ratio means the two count fields differ in parity
    assign odd_dcc = i_cfg.dcc_en & (i_cfg.low_cnt[0] ^ i_cfg.high_cnt[0]);
    assign delay   = i_cfg.initial_level_high ? {2'h0, i_cfg.coarse_phase_steps} + low6 + 6'h01
                   : {2'h0, i_cfg.coarse_phase_steps};

    always_comb
    begin
        s_d         = s_q;
        s_d.in_prev = i_in;
        if (!i_run || i_cfg.bypass)
        begin
            s_d.ph  = PH_HOLD;
            s_d.cnt = delay;
            s_d.out = (i_run && i_cfg.bypass) ? i_in : i_cfg.initial_level_high;
        end
        else
        begin
            case (s_q.ph)
                PH_HOLD:
                    s_d.ph = PH_DELAY;
                PH_DELAY:
                    if (rise)
                    begin
                        if (s_q.cnt == 6'h00)
                        begin
                            s_d.ph  = PH_HIGH;
                            s_d.out = 1'b1;
                            s_d.cnt = high6;
                        end
                        else
                            s_d.cnt = s_q.cnt - 6'h01;
                    end
                PH_HIGH:
                    if (rise)
                    begin
                        if (s_q.cnt != 6'h00)
                            s_d.cnt = s_q.cnt - 6'h01;
                        else if (odd_dcc)
                            s_d.ph = PH_FALL;
                        else
                        begin
                            s_d.ph  = PH_LOW;
                            s_d.out = 1'b0;
                            s_d.cnt = low6;
                        end
                    end
                PH_FALL:
                    // Ending high on the input's falling edge keeps odd ratios near 50%
                    if (fall)
                    begin
                        s_d.ph  = PH_LOW;
                        s_d.out = 1'b0;
                        s_d.cnt = low6;
                    end
                PH_LOW:
                    if (rise)
                    begin
                        if (s_q.cnt == 6'h00)
                        begin
                            s_d.ph  = PH_HIGH;
                            s_d.out = 1'b1;
                            s_d.cnt = high6;
                        end
                        else
                            s_d.cnt = s_q.cnt - 6'h01;
                    end
                default:
                    s_d.ph = PH_HOLD;
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else if (i_ce)
            s_q <= s_d;
    end

    assign o_out = s_q.out;

    property p_start_code;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && s_q.ph == PH_HOLD && !i_run && !i_cfg.bypass)
        |=> (s_q.cnt == ($past(i_cfg.initial_level_high)
             ? 6'd16 + {2'h0, $past(i_cfg.coarse_phase_steps)} - 6'd16
               + {2'h0, $past(i_cfg.low_cnt)} + 6'd1
             : {2'h0, $past(i_cfg.coarse_phase_steps)}));
    endproperty
    a_start_code: assert property (p_start_code) else $error("phase code load wrong");

    property p_hold_level;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !i_run) |=> (o_out == $past(i_cfg.initial_level_high));
    endproperty
    a_hold_level: assert property (p_hold_level) else $error("hold level wrong");

    property p_delay_end;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && i_run && !i_cfg.bypass && s_q.ph == PH_DELAY && rise && s_q.cnt == 6'h00)
        |=> (o_out && s_q.cnt == {2'h0, $past(i_cfg.high_cnt)});
    endproperty
    a_delay_end: assert property (p_delay_end) else $error("delay end wrong");

    property p_high_end;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && i_run && !i_cfg.bypass && s_q.ph == PH_HIGH && rise && s_q.cnt == 6'h00
         && !odd_dcc) |=> (!o_out && s_q.cnt == {2'h0, $past(i_cfg.low_cnt)});
    endproperty
    a_high_end: assert property (p_high_end) else $error("high phase length wrong");

    property p_odd_stretch;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && i_run && !i_cfg.bypass && s_q.ph == PH_HIGH && rise && s_q.cnt == 6'h00
         && odd_dcc) |=> (o_out && s_q.ph == PH_FALL);
    endproperty
    a_odd_stretch: assert property (p_odd_stretch) else $error("odd stretch lost");

    property p_low_hold;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && i_run && !i_cfg.bypass && s_q.ph == PH_LOW && s_q.cnt != 6'h00)
        |=> !o_out;
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low phase cut short");

endmodule : div_stage
`default_nettype wire

// ==== hdl/cdiv_top.sv ====
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "cdiv_regs.svh"
module cdiv_top
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_in_clk,
    input  wire logic        i_pre_clk,
    input  wire logic [10:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_ch3_clk,
    output logic             o_ch4_clk
);
    import cdiv_pkg::*;

    top_state_type t_q;
    top_state_type t_d;

    logic [1:0]    pin_level;
    logic          src;
    logic          run;
    logic [8:0]    idx;
    logic          req;
    logic          wr_take;
    logic [7:0]    wbyte;
    logic [7:0]    rd_byte;
    stage_cfg_type cfg3_1;
    stage_cfg_type cfg3_2;
    stage_cfg_type cfg4_1;
    stage_cfg_type cfg4_2;
    logic          out3_1;
    logic          out3_2;
    logic          out4_1;
    logic          out4_2;

    // Both clock sources arrive from pins, so they are sampled before use
    pin_sync #(
        .W (2)
    ) u_pins (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_pin      ({i_pre_clk, i_in_clk}),
        .o_level    (pin_level)
    );

    // The prescaler output is divided by the same stages as the direct pin; only the source differs
    assign src = t_q.src_pre ? pin_level[1] : pin_level[0];
    assign run = ~t_q.hold;

    assign idx     = i_avs_address[10:2];
    assign req     = i_avs_read | i_avs_write;
    assign wr_take = i_avs_write & ~t_q.wait_req;
    assign wbyte   = i_avs_writedata[7:0];

    always_comb
    begin
        cfg3_1.low_cnt            = t_q.ch3.cnt1[7:4];
        cfg3_1.high_cnt           = t_q.ch3.cnt1[3:0];
        cfg3_1.coarse_phase_steps = t_q.ch3.phase[3:0];
        cfg3_1.initial_level_high = t_q.ch3.start[`CDIV_START1_BIT];
        cfg3_1.bypass             = t_q.ch3.start[`CDIV_BYP1_BIT];
        cfg3_1.dcc_en             = ~t_q.ch3.dcc_off;
        cfg3_2.low_cnt            = t_q.ch3.cnt2[7:4];
        cfg3_2.high_cnt           = t_q.ch3.cnt2[3:0];
        cfg3_2.coarse_phase_steps = t_q.ch3.phase[7:4];
        cfg3_2.initial_level_high = t_q.ch3.start[`CDIV_START2_BIT];
        cfg3_2.bypass             = t_q.ch3.start[`CDIV_BYP2_BIT];
        cfg3_2.dcc_en             = ~t_q.ch3.dcc_off;
        cfg4_1.low_cnt            = t_q.ch4.cnt1[7:4];
        cfg4_1.high_cnt           = t_q.ch4.cnt1[3:0];
        cfg4_1.coarse_phase_steps = t_q.ch4.phase[3:0];
        cfg4_1.initial_level_high = t_q.ch4.start[`CDIV_START1_BIT];
        cfg4_1.bypass             = t_q.ch4.start[`CDIV_BYP1_BIT];
        cfg4_1.dcc_en             = ~t_q.ch4.dcc_off;
        cfg4_2.low_cnt            = t_q.ch4.cnt2[7:4];
        cfg4_2.high_cnt           = t_q.ch4.cnt2[3:0];
        cfg4_2.coarse_phase_steps = t_q.ch4.phase[7:4];
        cfg4_2.initial_level_high = t_q.ch4.start[`CDIV_START2_BIT];
        cfg4_2.bypass   = t_q.ch4.start[`CDIV_BYP2_BIT];
        cfg4_2.dcc_en   = ~t_q.ch4.dcc_off;
    end

    // Second stage counts periods of the first stage's output
    div_stage u_ch3_s1 (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_in       (src),
        .i_run      (run),
        .i_cfg      (cfg3_1),
        .o_out      (out3_1)
    );

    div_stage u_ch3_s2 (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_in       (out3_1),
        .i_run      (run),
        .i_cfg      (cfg3_2),
        .o_out      (out3_2)
    );

    div_stage u_ch4_s1 (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_in       (src),
        .i_run      (run),
        .i_cfg      (cfg4_1),
        .o_out      (out4_1)
    );

    div_stage u_ch4_s2 (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_in       (out4_1),
        .i_run      (run),
        .i_cfg      (cfg4_2),
        .o_out      (out4_2)
    );

    always_comb
    begin
        case (idx)
            `CDIV_CH3_CNT1:
                rd_byte = t_q.ch3.cnt1;
            `CDIV_CH3_PHASE:
                rd_byte = t_q.ch3.phase;
            `CDIV_CH3_CNT2:
                rd_byte = t_q.ch3.cnt2;
            `CDIV_CH3_START:
                rd_byte = t_q.ch3.start;
            `CDIV_CH3_DUTY:
                rd_byte = {7'h00, t_q.ch3.dcc_off};
            `CDIV_CH4_CNT1:
                rd_byte = t_q.ch4.cnt1;
            `CDIV_CH4_PHASE:
                rd_byte = t_q.ch4.phase;
            `CDIV_CH4_CNT2:
                rd_byte = t_q.ch4.cnt2;
            `CDIV_CH4_START:
                rd_byte = t_q.ch4.start;
            `CDIV_CH4_DUTY:
                rd_byte = {7'h00, t_q.ch4.dcc_off};
            `CDIV_CTRL:
                rd_byte = {6'h00, t_q.src_pre, t_q.hold};
            `CDIV_STATUS:
                rd_byte = {2'h0, t_q.ch4_clk, t_q.ch3_clk, out4_2, out4_1, out3_2, out3_1};
            default:
                rd_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        t_d          = t_q;
        t_d.ch3_clk  = out3_2;
        t_d.ch4_clk  = out4_2;
        t_d.wait_req = 1'b1;
        // One wait cycle: read data settle while waitrequest is still high
        if (req && t_q.wait_req)
        begin
            t_d.wait_req = 1'b0;
            t_d.rdata    = {24'h000000, rd_byte};
        end
        if (wr_take)
        begin
            case (idx)
                `CDIV_CH3_CNT1:
                    t_d.ch3.cnt1 = wbyte;
                `CDIV_CH3_PHASE:
                    t_d.ch3.phase = wbyte;
                `CDIV_CH3_CNT2:
                    t_d.ch3.cnt2 = wbyte;
                `CDIV_CH3_START:
                    t_d.ch3.start = wbyte;
                `CDIV_CH3_DUTY:
                    t_d.ch3.dcc_off = wbyte[`CDIV_DUTY_OFF_BIT];
                `CDIV_CH4_CNT1:
                    t_d.ch4.cnt1 = wbyte;
                `CDIV_CH4_PHASE:
                    t_d.ch4.phase = wbyte;
                `CDIV_CH4_CNT2:
                    t_d.ch4.cnt2 = wbyte;
                `CDIV_CH4_START:
                    t_d.ch4.start = wbyte;
                `CDIV_CH4_DUTY:
                    t_d.ch4.dcc_off = wbyte[`CDIV_DUTY_OFF_BIT];
                `CDIV_CTRL:
                begin
                    t_d.hold    = wbyte[`CDIV_HOLD_BIT];
                    t_d.src_pre = wbyte[`CDIV_SRC_BIT];
                end
                default:
                    t_d.hold = t_q.hold;
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            t_q             <= '0;
            t_q.ch3.cnt1    <= `CDIV_REG_RESET;
            t_q.ch3.phase   <= `CDIV_REG_RESET;
            t_q.ch3.cnt2    <= `CDIV_REG_RESET;
            t_q.ch3.start   <= `CDIV_REG_RESET;
            t_q.ch4.cnt1    <= `CDIV_REG_RESET;
            t_q.ch4.phase   <= `CDIV_REG_RESET;
            t_q.ch4.cnt2    <= `CDIV_REG_RESET;
            t_q.ch4.start   <= `CDIV_REG_RESET;
            t_q.wait_req    <= 1'b1;
        end
        else if (i_ce)
        begin
            t_q <= t_d;
        end
    end

    assign o_avs_readdata    = t_q.rdata;
    assign o_avs_waitrequest = t_q.wait_req;
    assign o_ch3_clk         = t_q.ch3_clk;
    assign o_ch4_clk         = t_q.ch4_clk;

    property p_ch3_start;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && wr_take && idx == `CDIV_CH3_START)
        |=> (cfg3_1.initial_level_high == $past(i_avs_writedata[0])
             && cfg3_2.initial_level_high == $past(i_avs_writedata[1]));
    endproperty
    a_ch3_start: assert property (p_ch3_start) else $error("ch3 start-high not taken");

    property p_ch4_phase;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && wr_take && idx == `CDIV_CH4_PHASE)
        |=> (cfg4_1.coarse_phase_steps == $past(i_avs_writedata[3:0])
             && cfg4_2.coarse_phase_steps == $past(i_avs_writedata[7:4]));
    endproperty
    a_ch4_phase: assert property (p_ch4_phase) else $error("ch4 offsets not taken");

    property p_dcc_off;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && wr_take && idx == `CDIV_CH3_DUTY && i_avs_writedata[0])
        |=> (!cfg3_1.dcc_en && !cfg3_2.dcc_en);
    endproperty
    a_dcc_off: assert property (p_dcc_off) else $error("correction not disabled");

    property p_bus_answer;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && req && o_avs_waitrequest) |=> (!o_avs_waitrequest ##1 o_avs_waitrequest);
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

endmodule : cdiv_top
`default_nettype wire

// ==== dv/test_cdiv_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cdiv_regs.svh"
module test_cdiv_top;
import cdiv_pkg::*;

logic             i_core_clk = 1'b0;
logic             i_rst_n    = 1'b0;
logic             i_in_clk   = 1'b0;
logic             i_pre_clk  = 1'b0;
logic      [10:0] addr       = 11'h000;
logic             rd         = 1'b0;
logic             wr         = 1'b0;
logic      [31:0] wdata      = 32'h0000_0000;
wire logic [31:0] rdata;
wire logic        wait_req;
wire logic        ch3;
wire logic        ch4;
logic      [31:0] got;
int               bad_count  = 0;
int               checked    = 0;
int               in_cnt     = 0;
int               pre_cnt    = 0;
int               hi;
int               lo;
logic      [55:0] dt [10];

always #12.5 i_core_clk = ~i_core_clk;

cdiv_top cdiv_top_inst (
    .i_core_clk       (i_core_clk),
    .i_rst_n          (i_rst_n),
    .i_ce             (1'b1),
    .i_in_clk         (i_in_clk),
    .i_pre_clk        (i_pre_clk),
    .i_avs_address    (addr),
    .i_avs_read       (rd),
    .i_avs_write      (wr),
    .i_avs_writedata  (wdata),
    .o_avs_readdata   (rdata),
    .o_avs_waitrequest(wait_req),
    .o_ch3_clk        (ch3),
    .o_ch4_clk        (ch4)
);

// Direct pin: 25% duty, 8 cycles; prescaler pin: ratio 3 of a 25% source, 5 of 12 high
always @(posedge i_core_clk)
begin
    in_cnt    <= (in_cnt + 1) % 8;
    i_in_clk  <= (in_cnt < 2);
    pre_cnt   <= (pre_cnt + 1) % 12;
    i_pre_clk <= (pre_cnt < 5);
end

task automatic complete_run;
begin
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
end
endtask : complete_run

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
begin
    checked++;
    if (seen !== exp)
    begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
end
endtask : check

// Holds the request until waitrequest is sampled low, as the bus demands
task automatic bus(input logic is_wr, input logic [8:0] idx, input logic [7:0] d);
    int n;
begin
    n = 0;
    @(posedge i_core_clk);
    addr  <= {idx, 2'b00};
    rd    <= !is_wr;
    wr    <= is_wr;
    wdata <= {24'h000000, d};
    do
    begin
        @(posedge i_core_clk);
        n++;
    end while (wait_req !== 1'b0 && n < 50);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
        check(32'h0000_0BAD, 32'h0000_0000);
end
endtask : bus

task automatic wait_lvl(input logic v, inout int n, output int c);
begin
    c = 0;
    while (ch3 !== v && n < 1000)
    begin
        @(posedge i_core_clk);
        n++;
        c++;
    end
end
endtask : wait_lvl

// Skips one whole cycle so start-up transients are not measured
task automatic duty(output int h, output int l);
    int n;
    int c;
begin
    n = 0;
    wait_lvl(1'b1, n, c);
    wait_lvl(1'b0, n, c);
    wait_lvl(1'b1, n, c);
    wait_lvl(1'b0, n, h);
    wait_lvl(1'b1, n, l);
end
endtask : duty

task automatic phase(input logic [7:0] c1, c2, st3, st4, ph4, input logic lvl, input int exp);
    int n;
    int t3;
    int t4;
begin
    bus(1'b1, `CDIV_CTRL, 8'h01);
    bus(1'b1, `CDIV_CH3_CNT1, c1);
    bus(1'b1, `CDIV_CH3_CNT2, c2);
    bus(1'b1, `CDIV_CH3_START, st3);
    bus(1'b1, `CDIV_CH3_PHASE, 8'h00);
    bus(1'b1, `CDIV_CH4_CNT1, c1);
    bus(1'b1, `CDIV_CH4_CNT2, c2);
    bus(1'b1, `CDIV_CH4_START, st4);
    bus(1'b1, `CDIV_CH4_PHASE, ph4);
    repeat (8) @(posedge i_core_clk);
    check({31'h0, ch4}, {31'h0, lvl});
    bus(1'b1, `CDIV_CTRL, 8'h00);
    n = 0;
    t3 = -1;
    t4 = -1;
    while ((t3 < 0 || t4 < 0) && n < 1000)
    begin
        @(posedge i_core_clk);
        n++;
        if (t3 < 0 && ch3 !== 1'b0)
            t3 = n;
        if (t4 < 0 && ch4 !== lvl)
            t4 = n;
    end
    check(32'(t4 - t3), 32'(exp));
end
endtask : phase

initial
begin
    repeat (20000) @(posedge i_core_clk);
    check(32'h0000_0DED, 32'h0000_0000);
    complete_run();
end

initial
begin
    // Fields: source, counts1, counts2, start, correction off, high, low
    dt[0] = 56'h00_11_00_20_00_10_10;
    dt[1] = 56'h00_10_00_20_00_0A_0E;
    dt[2] = 56'h00_10_00_00_00_18_18;
    dt[3] = 56'h00_10_10_00_00_22_26;
    dt[4] = 56'h00_00_00_30_00_02_06;
    dt[5] = 56'h00_10_00_20_01_08_10;
    dt[6] = 56'h01_00_00_30_00_05_07;
    dt[7] = 56'h01_10_00_20_00_11_13;
    dt[8] = 56'h01_10_10_00_00_35_37;
    dt[9] = 56'h01_11_00_20_00_18_18;
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 9'h199; i <= 9'h1A5; i++)
    begin
        bus(1'b0, 9'(i), 8'h00);
        // Status shows live divider levels, which run from reset on
        check(got & ((i == 9'h1A5) ? 32'hFFFF_FFC0 : 32'hFFFF_FFFF), 32'h0000_0000);
    end
    $display("test reset values done");
    for (int i = 9'h199; i <= 9'h1A1; i++)
    begin
        if (i != 9'h19D)
        begin
            bus(1'b1, 9'(i), 8'(i) ^ 8'hA5);
            bus(1'b0, 9'(i), 8'h00);
            check(got, {24'h000000, 8'(i) ^ 8'hA5});
            bus(1'b1, 9'(i), 8'h00);
        end
    end
    bus(1'b1, 9'h1A3, 8'h5A);
    bus(1'b0, 9'h1A3, 8'h00);
    check(got, 32'h0000_0000);
    $display("test register access done");
    for (int i = 0; i < 10; i++)
    begin
        bus(1'b1, `CDIV_CTRL, {6'h00, dt[i][48], 1'b1});
        bus(1'b1, `CDIV_CH3_CNT1, dt[i][47:40]);
        bus(1'b1, `CDIV_CH3_CNT2, dt[i][39:32]);
        bus(1'b1, `CDIV_CH3_START, dt[i][31:24]);
        bus(1'b1, `CDIV_CH3_DUTY, dt[i][23:16]);
        bus(1'b1, `CDIV_CTRL, {6'h00, dt[i][48], 1'b0});
        duty(hi, lo);
        check(32'(hi), {24'h000000, dt[i][15:8]});
        check(32'(lo), {24'h000000, dt[i][7:0]});
    end
    $display("test duty cycles done");
    phase(8'h11, 8'h00, 8'h20, 8'h20, 8'h05, 1'b0, 40);
    phase(8'h11, 8'h00, 8'h20, 8'h23, 8'h02, 1'b1, 48);
    phase(8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 1'b0, 48);
    phase(8'h00, 8'h00, 8'h00, 8'h02, 8'h10, 1'b1, 48);
    $display("test phase offsets done");
    complete_run();
end

endmodule : test_cdiv_top
`default_nettype wire
